// ==== design/ucr_pkg.sv ====
package ucr_pkg;
    // byte addresses of the mapped registers
    localparam logic [11:0] ADDR_MCR_HI = 12'h700;
    localparam logic [11:0] ADDR_MCR_LO = 12'h701;
    localparam logic [11:0] ADDR_ILR = 12'h704;
    localparam logic [11:0] ADDR_IVR = 12'h705;
    localparam logic [11:0] ADDR_CHANNEL_MODE_ONE = 12'h710;
    localparam logic [11:0] ADDR_MR1B = 12'h718;
    // module occupies 0x700..0x73F
    localparam logic [5:0] REGION_TAG = 6'h1C;
    // reset values and writable-bit masks
    localparam logic [15:0] MCR_RST = 16'h0080;
    localparam logic [7:0] MCR_HI_MASK = 8'hF0;
    localparam logic [7:0] MCR_LO_MASK = 8'h8F;
    localparam logic [7:0] ILR_RST = 8'h00;
    localparam logic [7:0] ILR_MASK = 8'h07;
    localparam logic [7:0] IVR_RST = 8'h0F;
    localparam logic [7:0] MR1_RST = 8'h00;
    localparam logic [3:0] IARB_NONE = 4'h0;
    localparam logic [2:0] LEVEL_NONE = 3'h0;
    localparam logic [3:0] CHAR_LEN_BASE = 4'h5;

    typedef struct packed {
        logic module_stop;
        logic [1:0] freeze_select;
        logic cts_capture_clock_select;
        logic [3:0] rsvd_hi;
        logic supervisor_only_space;
        logic [2:0] rsvd_lo;
        logic [3:0] interrupt_arbitration_id;
    } ucr_mcr_t;

    typedef struct packed {
        logic rx_flow_control_enable;
        logic rx_interrupt_source_select;
        logic error_accumulate_mode;
        logic [1:0] parity_mode;
        logic parity_type;
        logic [1:0] char_length;
    } ucr_mode_t;

    typedef enum logic [1:0] {
        PAR_WITH = 2'h0,
        PAR_FORCE = 2'h1,
        PAR_NONE = 2'h2,
        PAR_MULTIDROP = 2'h3
    } ucr_parity_t;

    typedef struct packed {
        logic break_received;
        logic framing_fault;
        logic parity_fault;
    } ucr_err_t;

    typedef struct packed {
        logic parity_on;
        logic parity_forced;
        logic odd_or_high;
        logic multidrop;
        logic address_char;
        logic [3:0] data_bits;
    } ucr_fmt_t;

    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_MCR_HI = 3'h1,
        SEL_MCR_LO = 3'h2,
        SEL_ILR = 3'h3,
        SEL_IVR = 3'h4,
        SEL_CHANNEL_MODE_ONE = 3'h5,
        SEL_MR1B = 3'h6
    } ucr_sel_t;
endpackage

// ==== design/ucr_sync.sv ====
`timescale 1ns/100ps
module ucr_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] out_ff;

    // two stages; only the second stage is ever read
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            out_ff <= '0;
        end else begin
            meta_ff <= d;
            out_ff <= meta_ff;
        end
    end
    assign q = out_ff;
endmodule // ucr_sync

// ==== design/ucr_chan.sv ====
`timescale 1ns/100ps
module ucr_chan (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic soft_rst,
    input ucr_pkg::ucr_mode_t mode,
    input wire logic tx_rts_enable,
    input wire logic op_rts_bit,
    input wire logic rx_start_valid,
    input wire logic rx_fifo_full,
    input wire logic rx_ready,
    input wire logic top_new,
    input ucr_pkg::ucr_err_t top_err,
    input wire logic reset_err_cmd,
    input wire logic freeze_on,
    input wire logic tx_boundary,
    input wire logic rx_boundary,
    input wire logic tx_break,
    output logic rts_n,
    output logic isr_rx_bit,
    output ucr_pkg::ucr_err_t err_status,
    output ucr_pkg::ucr_fmt_t fmt,
    output logic tx_freeze,
    output logic rx_freeze
);
    import ucr_pkg::*;

    logic flow_ok, nxt_hold, hold_ff, rts_n_ff, isr_ff, txf_ff, rxf_ff;
    ucr_err_t acc_ff, nxt_acc, err_ff;
    ucr_fmt_t fmt_ff, nxt_fmt;
    ucr_parity_t par;

    // format decode
    assign par = ucr_parity_t'(mode.parity_mode);
    assign nxt_fmt.parity_on = (par == PAR_WITH) || (par == PAR_FORCE);
    assign nxt_fmt.parity_forced = (par == PAR_FORCE);
    assign nxt_fmt.odd_or_high = mode.parity_type && (par != PAR_NONE);
    assign nxt_fmt.multidrop = (par == PAR_MULTIDROP);
    assign nxt_fmt.address_char = (par == PAR_MULTIDROP) && mode.parity_type;
    assign nxt_fmt.data_bits = CHAR_LEN_BASE + {2'h0, mode.char_length};

    // both ends asking for rts control is invalid, so fall back to the port
    assign flow_ok = mode.rx_flow_control_enable && !tx_rts_enable;
    assign nxt_hold = !flow_ok ? 1'b0 :
                      (rx_start_valid && rx_fifo_full) ? 1'b1 :
                      (!rx_fifo_full) ? 1'b0 : hold_ff;
    // a new top character while clearing still counts: set wins
    assign nxt_acc = top_new ? ((reset_err_cmd ? '0 : acc_ff) | top_err) :
                     (reset_err_cmd ? '0 : acc_ff);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_ff <= 1'b0;
            rts_n_ff <= 1'b1;
            acc_ff <= '0;
        end else if (soft_rst) begin
            hold_ff <= 1'b0;
            rts_n_ff <= 1'b1;
            acc_ff <= '0;
        end else begin
            hold_ff <= nxt_hold;
            rts_n_ff <= flow_ok ? nxt_hold : !op_rts_bit;
            acc_ff <= nxt_acc;
        end
    end

    // status views and freeze; a sending-break transmitter never freezes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            isr_ff <= 1'b0;
            err_ff <= '0;
            fmt_ff <= '0;
            txf_ff <= 1'b0;
            rxf_ff <= 1'b0;
        end else begin
            isr_ff <= mode.rx_interrupt_source_select ? rx_fifo_full : rx_ready;
            err_ff <= mode.error_accumulate_mode ? nxt_acc : top_err;
            fmt_ff <= nxt_fmt;
            txf_ff <= freeze_on && (txf_ff || (tx_boundary && !tx_break));
            rxf_ff <= freeze_on && (rxf_ff || rx_boundary);
        end
    end

    assign rts_n = rts_n_ff;
    assign isr_rx_bit = isr_ff;
    assign err_status = err_ff;
    assign fmt = fmt_ff;
    assign tx_freeze = txf_ff;
    assign rx_freeze = rxf_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    freeze_off_a: assert property (!freeze_on |=> !tx_freeze && !rx_freeze)
        else $error("freeze held without request");
    break_nofrz_a: assert property (tx_break && !tx_freeze |=> !tx_freeze)
        else $error("transmitter froze during break");
    rts_conflict_a: assert property (mode.rx_flow_control_enable && tx_rts_enable
        && !soft_rst |=> rts_n == !$past(op_rts_bit))
        else $error("rts not from output port on conflict");
    rts_full_a: assert property (flow_ok && rx_start_valid && rx_fifo_full
        && !soft_rst |=> rts_n)
        else $error("rts not negated on full fifo");
endmodule // ucr_chan

// ==== design/ucr_top.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - stop halts crystal and external clocks low; bus clock keeps running.
// - in stop, any access except the config register gets bus error.
// - processor reset instruction resets all registers except the config register.
// - freeze select upper bit freezes at character boundary on debug halt.
// - channels freeze independently; a break-sending transmitter never freezes.
// - clear-to-send sampled on external clock rising edge if selected, else crystal.
// - supervisor space bit gates user access to programmable-privilege registers.
// - arbitration id resolves same-level requests; zero means no arbitration.
// - interrupt level is presented on request lines; zero requests nothing.
// - eight-bit vector supplied at acknowledge, resets to 0F.
// - with flow control, rts negates on start bit into full fifo.
// - without flow control, rts follows the output port bit.
// - receiver and transmitter rts control both on disables rts control.
// - interrupt status bit shows fifo full or receiver ready by select.
// - accumulate mode ORs error bits since reset-error command, else top only.
// - parity mode adds parity on transmit, checks on receive, or multidrop.
// - parity mode and type decode to even/odd, forced, none, multidrop.
// - character length codes give five to eight data bits.
// - byte accesses without wait; reserved reads zero, ignored writes complete.
module ucr_top (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic bus_req,
    input wire logic bus_wr,
    input wire logic bus_super,
    input wire logic [11:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic bus_ack,
    output logic bus_berr,
    output logic [7:0] bus_rdata,
    input wire logic cpu_reset_instr,
    input wire logic xtal_clk_in,
    input wire logic ext_clk_in,
    output logic xtal_clk_run,
    output logic ext_clk_run,
    input wire logic debug_halt_request,
    input wire logic [1:0] cts_n_in,
    output logic [1:0] cts_n_captured,
    input wire logic irq_pending,
    output logic [2:0] irq_line_level,
    input wire logic iack_cycle,
    input wire logic [2:0] iack_level,
    output logic iack_arbitrate,
    output logic [3:0] iack_arb_id,
    output logic [7:0] iack_vector,
    input wire logic [1:0] tx_rts_enable,
    input wire logic [1:0] op_rts_bit,
    input wire logic [1:0] rx_start_valid,
    input wire logic [1:0] rx_fifo_full,
    input wire logic [1:0] rx_ready,
    input wire logic [1:0] top_new,
    input ucr_pkg::ucr_err_t [1:0] top_err,
    input wire logic [1:0] reset_err_cmd,
    input wire logic [1:0] tx_boundary,
    input wire logic [1:0] rx_boundary,
    input wire logic [1:0] tx_break,
    output logic [1:0] rts_n,
    output logic [1:0] isr_rx_bit,
    output ucr_pkg::ucr_err_t [1:0] err_status,
    output ucr_pkg::ucr_fmt_t [1:0] char_fmt,
    output logic [1:0] tx_freeze,
    output logic [1:0] rx_freeze
);
    import ucr_pkg::*;

    logic rst_n;
    logic [3:0] pin_s;
    logic xtal_s, ext_s, xtal_prev_ff, ext_prev_ff;
    logic xtal_rise, ext_rise, cap_edge;
    logic [1:0] cts_cap_ff;
    logic xtal_run_ff, ext_run_ff;
    logic [15:0] mcr_ff;
    ucr_mcr_t module_config;
    logic [7:0] ilr_ff, ivr_ff;
    logic [7:0] mr1_ff [2];
    ucr_sel_t sel;
    logic in_region, is_mcr, perm_super, is_mr1, access_err, wr_ok;
    logic [7:0] rd_mux;
    logic ack_ff, berr_ff;
    logic [7:0] rdata_ff;
    logic [2:0] irq_lvl_ff;
    logic arb_ff;
    logic [3:0] arb_id_ff;
    logic [7:0] vec_ff;
    logic stop, freeze_on;

    // reset release through two flip-flops
    ucr_sync #(.W(1)) u_rst_sync (
        .ref_clk(ref_clk),
        .rst_n(nrst),
        .d(1'b1),
        .q(rst_n)
    );

    // pins from other clocks: crystal, external clock and both cts inputs
    ucr_sync #(.W(4)) u_pin_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .d({cts_n_in, ext_clk_in, xtal_clk_in}),
        .q(pin_s)
    );

    assign xtal_s = pin_s[0];
    assign ext_s = pin_s[1];
    assign module_config = ucr_mcr_t'(mcr_ff);
    assign stop = module_config.module_stop;

    // edge detect on synchronised copies only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            xtal_prev_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end else begin
            xtal_prev_ff <= xtal_s;
            ext_prev_ff <= ext_s;
        end
    end

    assign xtal_rise = xtal_s && !xtal_prev_ff;
    assign ext_rise = ext_s && !ext_prev_ff;
    assign cap_edge = !stop && (module_config.cts_capture_clock_select ? ext_rise : xtal_rise);

    // clocks run only while enabled; forcing low stops them on the low phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            xtal_run_ff <= 1'b0;
            ext_run_ff <= 1'b0;
        end else begin
            xtal_run_ff <= xtal_s && !stop;
            ext_run_ff <= ext_s && !stop;
        end
    end

    // cts capture holds between edges of the selected clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cts_cap_ff <= 2'h3;
        end else if (cap_edge) begin
            cts_cap_ff <= pin_s[3:2];
        end
    end

    // address decode
    assign in_region = bus_req && (bus_addr[11:6] == REGION_TAG);
    always_comb begin
        if (bus_addr == ADDR_MCR_HI) begin
            sel = SEL_MCR_HI;
        end else if (bus_addr == ADDR_MCR_LO) begin
            sel = SEL_MCR_LO;
        end else if (bus_addr == ADDR_ILR) begin
            sel = SEL_ILR;
        end else if (bus_addr == ADDR_IVR) begin
            sel = SEL_IVR;
        end else if (bus_addr == ADDR_CHANNEL_MODE_ONE) begin
            sel = SEL_CHANNEL_MODE_ONE;
        end else if (bus_addr == ADDR_MR1B) begin
            sel = SEL_MR1B;
        end else begin
            sel = SEL_NONE;
        end
    end

    // privilege and stop checks; unmapped in-region bytes answer quietly outside stop
    assign is_mcr = (sel == SEL_MCR_HI) || (sel == SEL_MCR_LO);
    assign perm_super = is_mcr || (sel == SEL_ILR) || (sel == SEL_IVR);
    assign is_mr1 = (sel == SEL_CHANNEL_MODE_ONE) || (sel == SEL_MR1B);
    assign access_err = in_region && ((stop && !is_mcr) ||
                        (!bus_super && (perm_super ||
                        (is_mr1 && module_config.supervisor_only_space))));
    assign wr_ok = in_region && bus_wr && !access_err;

    // config register: untouched by the reset instruction
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mcr_ff <= MCR_RST;
        end else if (wr_ok && (sel == SEL_MCR_HI)) begin
            mcr_ff[15:8] <= bus_wdata & MCR_HI_MASK;
        end else if (wr_ok && (sel == SEL_MCR_LO)) begin
            mcr_ff[7:0] <= bus_wdata & MCR_LO_MASK;
        end
    end

    // level and vector: reset by hardware reset and by reset instruction
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ilr_ff <= ILR_RST;
            ivr_ff <= IVR_RST;
        end else if (cpu_reset_instr) begin
            ilr_ff <= ILR_RST;
            ivr_ff <= IVR_RST;
        end else begin
            if (wr_ok && (sel == SEL_ILR)) begin
                ilr_ff <= bus_wdata & ILR_MASK;
            end
            if (wr_ok && (sel == SEL_IVR)) begin
                ivr_ff <= bus_wdata;
            end
        end
    end

    // read mux; reserved bytes and refused accesses read zero
    always_comb begin
        if (access_err) begin
            rd_mux = 8'h00;
        end else if (sel == SEL_MCR_HI) begin
            rd_mux = mcr_ff[15:8];
        end else if (sel == SEL_MCR_LO) begin
            rd_mux = mcr_ff[7:0];
        end else if (sel == SEL_ILR) begin
            rd_mux = ilr_ff;
        end else if (sel == SEL_IVR) begin
            rd_mux = ivr_ff;
        end else if (sel == SEL_CHANNEL_MODE_ONE) begin
            rd_mux = mr1_ff[0];
        end else if (sel == SEL_MR1B) begin
            rd_mux = mr1_ff[1];
        end else begin
            rd_mux = 8'h00;
        end
    end

    // one-cycle answer, no wait states
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
            berr_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            ack_ff <= in_region && !access_err;
            berr_ff <= access_err;
            rdata_ff <= (in_region && !bus_wr) ? rd_mux : 8'h00;
        end
    end

    assign bus_ack = ack_ff;
    assign bus_berr = berr_ff;
    assign bus_rdata = rdata_ff;

    // interrupt request level and acknowledge participation
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_lvl_ff <= LEVEL_NONE;
            arb_ff <= 1'b0;
            arb_id_ff <= IARB_NONE;
            vec_ff <= IVR_RST;
        end else begin
            irq_lvl_ff <= (irq_pending && !stop) ? ilr_ff[2:0] : LEVEL_NONE;
            arb_ff <= iack_cycle && irq_pending && !stop &&
                      (module_config.interrupt_arbitration_id != IARB_NONE) &&
                      (ilr_ff[2:0] != LEVEL_NONE) && (iack_level == ilr_ff[2:0]);
            arb_id_ff <= module_config.interrupt_arbitration_id;
            vec_ff <= ivr_ff;
        end
    end

    assign irq_line_level = irq_lvl_ff;
    assign iack_arbitrate = arb_ff;
    assign iack_arb_id = arb_id_ff;
    assign iack_vector = vec_ff;
    assign xtal_clk_run = xtal_run_ff;
    assign ext_clk_run = ext_run_ff;
    assign cts_n_captured = cts_cap_ff;

    // freeze request; channel clocks are stopped anyway while in stop mode
    assign freeze_on = module_config.freeze_select[1] && debug_halt_request && !stop;

    // per-channel mode register and its logic
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        localparam ucr_sel_t CH_SEL = (ch == 0) ? SEL_CHANNEL_MODE_ONE : SEL_MR1B;

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                mr1_ff[ch] <= MR1_RST;
            end else if (cpu_reset_instr) begin
                mr1_ff[ch] <= MR1_RST;
            end else if (wr_ok && (sel == CH_SEL)) begin
                mr1_ff[ch] <= bus_wdata;
            end
        end

        ucr_chan u_chan (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .soft_rst(cpu_reset_instr),
            .mode(ucr_mode_t'(mr1_ff[ch])),
            .tx_rts_enable(tx_rts_enable[ch]),
            .op_rts_bit(op_rts_bit[ch]),
            .rx_start_valid(rx_start_valid[ch]),
            .rx_fifo_full(rx_fifo_full[ch]),
            .rx_ready(rx_ready[ch]),
            .top_new(top_new[ch]),
            .top_err(top_err[ch]),
            .reset_err_cmd(reset_err_cmd[ch]),
            .freeze_on(freeze_on),
            .tx_boundary(tx_boundary[ch]),
            .rx_boundary(rx_boundary[ch]),
            .tx_break(tx_break[ch]),
            .rts_n(rts_n[ch]),
            .isr_rx_bit(isr_rx_bit[ch]),
            .err_status(err_status[ch]),
            .fmt(char_fmt[ch]),
            .tx_freeze(tx_freeze[ch]),
            .rx_freeze(rx_freeze[ch])
        );
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    clk_halt_a: assert property (stop |=> !xtal_clk_run && !ext_clk_run)
        else $error("internal clock running in stop");
    stop_berr_a: assert property (in_region && stop && !is_mcr |=> bus_berr && !bus_ack)
        else $error("no bus error in stop");
    stop_mcr_a: assert property (in_region && stop && is_mcr && bus_super
        |=> bus_ack && !bus_berr)
        else $error("config register refused in stop");
    keep_mcr_a: assert property (cpu_reset_instr && !(wr_ok && is_mcr)
        |=> $stable(mcr_ff))
        else $error("config register changed by reset instruction");
    soft_rst_a: assert property (cpu_reset_instr
        |=> ilr_ff == ILR_RST && ivr_ff == IVR_RST ##1 iack_vector == IVR_RST)
        else $error("vector or level not reset");
    cts_hold_a: assert property (!cap_edge |=> $stable(cts_n_captured))
        else $error("cts capture moved without selected edge");
    user_block_a: assert property (in_region && !bus_super && is_mr1
        && module_config.supervisor_only_space |=> bus_berr)
        else $error("user reached supervisor-only mode register");
    user_allow_a: assert property (in_region && !bus_super && is_mr1 && !stop
        && !module_config.supervisor_only_space |=> !bus_berr && bus_ack)
        else $error("user refused in user space");
    iarb_zero_a: assert property (module_config.interrupt_arbitration_id == IARB_NONE
        |=> !iack_arbitrate)
        else $error("arbitration with zero id");
    irq_zero_a: assert property (ilr_ff[2:0] == LEVEL_NONE
        |=> irq_line_level == LEVEL_NONE)
        else $error("request at level zero");
    rsvd_zero_a: assert property (in_region && !bus_wr && sel == SEL_NONE
        |=> bus_rdata == 8'h00)
        else $error("reserved location read non-zero");

    stop_c: cover property (wr_ok && sel == SEL_MCR_HI && bus_wdata[7]);
    freeze_c: cover property (tx_freeze[0] && !tx_freeze[1]);
    arb_c: cover property (iack_arbitrate);
    berr_c: cover property (bus_berr);
endmodule // ucr_top

// ==== test/ucr_cpu_model.sv ====
`timescale 1ns/100ps
// processor side of the byte bus
module ucr_cpu_model (
    input wire logic ref_clk,
    output logic bus_req,
    output logic bus_wr,
    output logic bus_super,
    output logic [11:0] bus_addr,
    output logic [7:0] bus_wdata,
    input wire logic bus_ack,
    input wire logic bus_berr,
    input wire logic [7:0] bus_rdata
);
    initial begin
        {bus_req, bus_wr, bus_super, bus_addr, bus_wdata} = '0;
    end
    // one byte, no wait: answer stands one cycle, so it is taken mid-cycle
    task automatic acc(input logic w, s, input logic [11:0] a, input logic [7:0] d,
        output logic [9:0] r);
        @(negedge ref_clk);
        bus_req = 1'h1;
        bus_wr = w;
        bus_super = s;
        bus_addr = a;
        bus_wdata = d;
        @(negedge ref_clk);
        r = {bus_berr, bus_ack, bus_rdata};
        bus_req = 1'h0;
        bus_wdata = ~d; // a released bus never keeps the old byte
    endtask
endmodule // ucr_cpu_model

// ==== test/tb.sv ====
`timescale 1ns/100ps
module tb;
    logic ref_clk, nrst, bus_req, bus_wr, bus_super, bus_ack, bus_berr;
    logic [11:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, iack_vector;
    logic cpu_reset_instr, xtal_clk_in, ext_clk_in, xtal_clk_run, ext_clk_run;
    logic debug_halt_request, irq_pending, iack_cycle, iack_arbitrate;
    logic [2:0] iack_level, irq_line_level;
    logic [3:0] iack_arb_id;
    logic [1:0] cts_n_in, cts_n_captured, tx_rts_enable, op_rts_bit, rx_start_valid;
    logic [1:0] rx_fifo_full, rx_ready, top_new, reset_err_cmd, tx_boundary, rx_boundary;
    logic [1:0] tx_break, rts_n, isr_rx_bit, tx_freeze, rx_freeze, pm;
    ucr_pkg::ucr_err_t [1:0] top_err, err_status;
    ucr_pkg::ucr_fmt_t [1:0] char_fmt;
    int bad_count, checks_done;
    logic [8:0] f;
    logic [1:0] seen;

    ucr_top dut (.*);
    ucr_cpu_model cpu (.*);

    // pin clocks at rates unrelated to the bus clock
    always #2.5 ref_clk = ~ref_clk;
    always #13.1 xtal_clk_in = ~xtal_clk_in;
    always #17.3 ext_clk_in = ~ext_clk_in;

    task automatic cy(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input logic [15:0] g, e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic ax(input logic w, s, input logic [11:0] a, input logic [7:0] d,
        input logic [1:0] er, input logic [7:0] eq);
        logic [9:0] r;
        cpu.acc(w, s, a, d, r);
        chk(r, {er, eq});
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        ax(1'h1, 1'h1, a, d, 2'h1, 8'h00);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        ax(1'h0, 1'h1, a, 8'h00, 2'h1, e);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // whole run is a few hundred cycles; this is far beyond it
    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end

    initial begin
        {ref_clk, xtal_clk_in, ext_clk_in, nrst, cpu_reset_instr, debug_halt_request} = '0;
        {irq_pending, iack_cycle, iack_level, tx_rts_enable, op_rts_bit, rx_start_valid} = '0;
        {rx_fifo_full, rx_ready, top_new, top_err, reset_err_cmd, tx_boundary} = '0;
        {rx_boundary, tx_break, bad_count, checks_done} = '0;
        cts_n_in = 2'h3;
        cy(3);
        nrst = 1'h1;
        cy(4);
        rd(12'h700, 8'h00);
        rd(12'h701, 8'h80);
        rd(12'h704, 8'h00);
        rd(12'h705, 8'h0F);
        wr(12'h702, 8'hFF);
        rd(12'h702, 8'h00);
        wr(12'h701, 8'hFF);
        rd(12'h701, 8'h8F);
        ax(1'h0, 1'h0, 12'h700, 8'h00, 2'h2, 8'h00);
        ax(1'h1, 1'h0, 12'h710, 8'h80, 2'h2, 8'h00);
        wr(12'h701, 8'h0F);
        ax(1'h1, 1'h0, 12'h710, 8'h80, 2'h1, 8'h00);
        rd(12'h710, 8'h80);
        // every parity and length code on both channels
        for (int i = 0; i < 32; i++) begin
            wr(12'h710, 8'(i));
            wr(12'h718, 8'(i));
            cy(2);
            pm = 2'(i >> 3);
            f = {pm < 2'h2, pm == 2'h1, i[2] && pm != 2'h2, pm == 2'h3,
                i[2] && pm == 2'h3, 4'h5 + 4'(i & 3)};
            chk(char_fmt[0], f);
            chk(char_fmt[1], f);
        end
        wr(12'h710, 8'h00);
        op_rts_bit = 2'h1;
        cy(2);
        chk(rts_n[0], 1'h0);
        wr(12'h710, 8'h80);
        rx_fifo_full = 2'h1;
        rx_start_valid = 2'h1;
        cy(1);
        rx_start_valid = 2'h0;
        cy(1);
        chk(rts_n[0], 1'h1);
        rx_fifo_full = 2'h0;
        cy(2);
        chk(rts_n[0], 1'h0);
        tx_rts_enable = 2'h1;
        op_rts_bit = 2'h0;
        cy(2);
        chk(rts_n[0], 1'h1);
        rx_fifo_full = 2'h1;
        wr(12'h710, 8'h40);
        cy(2);
        chk(isr_rx_bit[0], 1'h1);
        wr(12'h710, 8'h00);
        rx_fifo_full = 2'h0;
        rx_ready = 2'h1;
        cy(2);
        chk(isr_rx_bit[0], 1'h1);
        rx_ready = 2'h0;
        // two flagged characters pile up, then the clear command wipes them
        wr(12'h710, 8'h20);
        top_err[0] = 3'h4;
        top_new = 2'h1;
        cy(1);
        top_err[0] = 3'h1;
        cy(1);
        top_new = 2'h0;
        top_err[0] = 3'h2;
        cy(2);
        chk(err_status[0], 3'h5);
        reset_err_cmd = 2'h1;
        cy(1);
        reset_err_cmd = 2'h0;
        cy(2);
        chk(err_status[0], 3'h0);
        wr(12'h710, 8'h00);
        cy(2);
        chk(err_status[0], 3'h2);
        wr(12'h700, 8'h80);
        cy(2);
        repeat (40) begin
            cy(1);
            chk(xtal_clk_run | ext_clk_run, 1'h0);
        end
        ax(1'h0, 1'h1, 12'h704, 8'h00, 2'h2, 8'h00);
        rd(12'h701, 8'h0F);
        wr(12'h700, 8'h00);
        // both pin clocks must show up again once stop is cleared
        seen = 2'h0;
        repeat (40) begin
            cy(1);
            seen = seen | {ext_clk_run, xtal_clk_run};
        end
        chk(seen, 2'h3);
        wr(12'h704, 8'h05);
        cpu_reset_instr = 1'h1;
        cy(1);
        cpu_reset_instr = 1'h0;
        rd(12'h704, 8'h00);
        rd(12'h701, 8'h0F);
        irq_pending = 1'h1;
        cy(2);
        chk(irq_line_level, 3'h0);
        wr(12'h704, 8'h03);
        cy(2);
        chk(irq_line_level, 3'h3);
        iack_cycle = 1'h1;
        iack_level = 3'h3;
        cy(2);
        chk({iack_arbitrate, iack_arb_id, iack_vector}, 13'h1F0F);
        iack_cycle = 1'h0;
        // channel A sends a break, so only its receiver and channel B's sender stop
        wr(12'h700, 8'h40);
        debug_halt_request = 1'h1;
        tx_break = 2'h1;
        tx_boundary = 2'h3;
        rx_boundary = 2'h1;
        cy(1);
        {tx_boundary, rx_boundary} = '0;
        cy(1);
        chk({tx_freeze, rx_freeze}, 4'h9);
        wr(12'h700, 8'h20);
        cy(2);
        chk({tx_freeze, rx_freeze}, 4'h0);
        // capture follows the selected pin clock and holds while stopped
        wr(12'h700, 8'h10);
        cts_n_in = 2'h1;
        cy(40);
        chk(cts_n_captured, 2'h1);
        wr(12'h700, 8'h00);
        cts_n_in = 2'h2;
        cy(40);
        chk(cts_n_captured, 2'h2);
        wr(12'h700, 8'h80);
        cts_n_in = 2'h0;
        cy(40);
        chk(cts_n_captured, 2'h2);
        wrap_up();
    end
endmodule // tb
